/* File: rtl/align_check.sv */
// alignment and buffer split checks for one channel context
// assumes beat size codes 0..4 mean 1..16 bytes
`timescale 1ns/10ps
module align_check
  import chan_chk_pkg::*;
(
  // channel context and results
  chan_chk_if.chk c
);
  logic [7:0] smask;
  logic [7:0] dmask;
  logic [3:0] lane_off;

  // byte masks of the beat sizes and lane offset
  assign smask = (8'h01 << c.ccr[CCR_SRC_SIZE_LO +: 3]) - 8'h01;
  assign dmask = (8'h01 << c.ccr[CCR_DST_SIZE_LO +: 3]) - 8'h01;
  assign lane_off = c.dar[3:0] - c.sar[3:0];

  // fixed bursts must start on a beat boundary
  assign c.src_misaligned = !c.ccr[CCR_SRC_INC] &&
                            ((c.sar[7:0] & smask) != 8'h00);
  assign c.dst_misaligned = !c.ccr[CCR_DST_INC] &&
                            ((c.dar[7:0] & dmask) != 8'h00);
  // a beat splits unless the offset is a multiple of the source size
  assign c.split = (lane_off & smask[3:0]) != 4'h0;
endmodule : align_check

/* File: rtl/chan_chk_if.sv */
// interfaces between the checker top and its helper modules
// assumes the checks are purely combinational
`timescale 1ns/10ps
interface chan_chk_if;
  logic [31:0] sar;
  logic [31:0] dar;
  logic [31:0] ccr;
  logic src_misaligned;
  logic dst_misaligned;
  logic split;
  modport chk (input sar, dar, ccr,
               output src_misaligned, dst_misaligned, split);
  modport top (output sar, dar, ccr,
               input src_misaligned, dst_misaligned, split);
endinterface : chan_chk_if

interface instr_dec_if;
  logic [7:0] op;
  logic mgr;
  logic is_adnh;
  logic is_go;
  logic is_end;
  logic is_sev;
  logic is_ld;
  logic is_st;
  logic legal;
  logic ra;
  modport dec (input op, mgr,
               output is_adnh, is_go, is_end, is_sev, is_ld, is_st,
               legal, ra);
  modport top (output op, mgr,
               input is_adnh, is_go, is_end, is_sev, is_ld, is_st,
               legal, ra);
endinterface : instr_dec_if

/* File: rtl/chan_chk_pkg.sv */
// constants, register map and types for the channel program checker
// assumes one 40 MHz pclk domain and an apb3 register port
package chan_chk_pkg;

  localparam int NUM_CH = 8;
  localparam int CH_W = 3;

  // register byte offsets
  localparam logic [11:0] INT_STATUS_OFF = 12'h000;
  localparam logic [11:0] INT_CLEAR_OFF = 12'h004;
  localparam logic [11:0] INT_ENABLE_OFF = 12'h008;
  localparam logic [11:0] FAULT_STATUS_OFF = 12'h00c;
  localparam logic [11:0] FAULT_CLEAR_OFF = 12'h010;
  localparam logic [11:0] MGR_FAULT_OFF = 12'h014;
  localparam logic [11:0] INSN_OFF = 12'h018;
  localparam logic [11:0] EXEC_OFF = 12'h01c;
  localparam logic [11:0] CH_SEL_OFF = 12'h020;
  localparam logic [11:0] CH_SAR_OFF = 12'h024;
  localparam logic [11:0] CH_DAR_OFF = 12'h028;
  localparam logic [11:0] CH_CCR_OFF = 12'h02c;
  localparam logic [11:0] CH_FTYPE_OFF = 12'h030;
  localparam logic [11:0] CH_STATE_OFF = 12'h034;

  // interrupt status bit positions
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_CH_FAULT = 1;
  localparam int IRQ_MGR_FAULT = 2;
  localparam int IRQ_ABORT = 3;
  localparam int IRQ_W = 4;

  // channel control word fields
  localparam int CCR_SRC_INC = 0;
  localparam int CCR_SRC_SIZE_LO = 1;
  localparam int CCR_SRC_LEN_LO = 4;
  localparam int CCR_DST_INC = 14;
  localparam int CCR_DST_SIZE_LO = 15;

  // channel fault type bits
  localparam int FT_UNDEF = 0;
  localparam int FT_UNALIGNED = 1;

  // instruction field positions in the insn register
  localparam int INSN_CH_LO = 24;
  localparam int INSN_MGR = 27;
  localparam int INSN_W = 28;

  // opcode bytes
  localparam logic [7:0] OP_END = 8'h00;
  localparam logic [7:0] OP_LD = 8'h04;
  localparam logic [7:0] OP_ST = 8'h08;
  localparam logic [7:0] OP_NOP = 8'h18;
  localparam logic [7:0] OP_SEV = 8'h34;
  localparam logic [7:0] OP_WFE = 8'h36;
  localparam logic [7:0] OP_GO = 8'ha0;
  localparam logic [7:0] OP_ADNH = 8'h5c;
  localparam logic [7:0] OP_RA_MASK = 8'hfd;
  localparam logic [15:0] ONES_HI = 16'hffff;

  // shared merge buffer size in bytes
  localparam logic [11:0] MERGE_BYTES = 12'h100;

  // channel thread states
  localparam logic [1:0] CH_STOPPED = 2'b00;
  localparam logic [1:0] CH_EXEC = 2'b01;
  localparam logic [1:0] CH_FAULTC = 2'b11;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_RUN = 2'b01,
    EX_DONE = 2'b11
  } exec_e;

endpackage : chan_chk_pkg

/* File: rtl/chan_prog_check.sv */
// channel program checker: apb registers, instruction step, faults
// assumes an apb3 master on pclk and no other clock
//
// Operation
// - fixed source burst with unaligned source address is a program error
// - fixed destination burst with unaligned destination is a program error
// - on fault: no-op, set fault bit, record type, faulting-completing
// - merge buffer demand above its size raises an abort
// - channel 0 updates never corrupt split beats of other channels
// - a beat crossing the bus width wrap splits over two lines
// - no split when lane offset is a multiple of source size
// - one shared interrupt, no record of the raising channel
// - go only in manager; end, nop, sev, wfe anywhere; rest channels
// - adnh one-extends the 16-bit immediate and adds in 32 bits
// - adnh drops the carry so addresses wrap
// - adnh is opcode 0101_11r0, then immediate low then high byte
// - select 0 updates the source address, 1 the destination
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
module chan_prog_check
  import chan_chk_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [NUM_CH-1:0][31:0] sar;
    logic [NUM_CH-1:0][31:0] dar;
    logic [NUM_CH-1:0][31:0] ccr;
    logic [NUM_CH-1:0][7:0] ftype;
    logic [NUM_CH-1:0][1:0] chst;
    logic [NUM_CH-1:0] fsr;
    logic [IRQ_W-1:0] int_stat;
    logic [IRQ_W-1:0] int_en;
    logic mgr_fault;
    logic [INSN_W-1:0] insn;
    logic [CH_W-1:0] ch_sel;
    exec_e ex;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } st_s;

  st_s r;
  st_s n;

  chan_chk_if ck_run ();
  chan_chk_if ck_view ();
  instr_dec_if dc ();

  logic setup;
  logic acc;
  logic wr;
  logic [CH_W-1:0] ich;
  logic [15:0] imm;
  logic [31:0] base;
  logic [31:0] exp_addr;
  logic [16:0] neg_mag;
  logic run_ch;
  logic run_mgr;

  // instruction fields of the pending step
  assign ich = r.insn[INSN_CH_LO +: CH_W];
  assign imm = r.insn[23:8];
  assign base = dc.ra ? r.dar[ich] : r.sar[ich];
  // one-extended immediate, 32-bit sum with the carry dropped
  assign exp_addr = base + {ONES_HI, imm};
  assign neg_mag = 17'h10000 - {1'b0, imm};
  assign run_mgr = (r.ex == EX_RUN) && r.insn[INSN_MGR];
  assign run_ch = (r.ex == EX_RUN) && !r.insn[INSN_MGR] &&
                  (r.chst[ich] == CH_EXEC);

  // checks on the executing channel and on the viewed channel
  assign ck_run.sar = r.sar[ich];
  assign ck_run.dar = r.dar[ich];
  assign ck_run.ccr = r.ccr[ich];
  assign ck_view.sar = r.sar[r.ch_sel];
  assign ck_view.dar = r.dar[r.ch_sel];
  assign ck_view.ccr = r.ccr[r.ch_sel];
  assign dc.op = r.insn[7:0];
  assign dc.mgr = r.insn[INSN_MGR];

  align_check u_chk_run (
    .c (ck_run)
  );

  align_check u_chk_view (
    .c (ck_view)
  );

  instr_decode u_dec (
    .d (dc)
  );

  // apb phases
  assign setup = psel && !penable;
  assign acc = psel && penable && r.pready;
  assign wr = acc && pwrite;

  // next state: bus access, instruction step, sticky status
  always_comb begin
    logic [15:0] demand;
    logic mapped;
    logic [31:0] rd;
    demand = 16'h0000;
    mapped = 1'b1;
    rd = 32'h0000_0000;
    n = r;
    n.irq = |(r.int_stat & r.int_en);
    n.pready = setup;
    n.pslverr = 1'b0;

    // read data and address decode in the setup cycle
    case (paddr)
      INT_STATUS_OFF: rd = {28'h0, r.int_stat};
      INT_CLEAR_OFF: rd = 32'h0000_0000;
      INT_ENABLE_OFF: rd = {28'h0, r.int_en};
      FAULT_STATUS_OFF: rd = {24'h0, r.fsr};
      FAULT_CLEAR_OFF: rd = 32'h0000_0000;
      MGR_FAULT_OFF: rd = {31'h0, r.mgr_fault};
      INSN_OFF: rd = {4'h0, r.insn};
      EXEC_OFF: rd = {31'h0, r.ex != EX_IDLE};
      CH_SEL_OFF: rd = {29'h0, r.ch_sel};
      CH_SAR_OFF: rd = r.sar[r.ch_sel];
      CH_DAR_OFF: rd = r.dar[r.ch_sel];
      CH_CCR_OFF: rd = r.ccr[r.ch_sel];
      CH_FTYPE_OFF: rd = {24'h0, r.ftype[r.ch_sel]};
      CH_STATE_OFF: rd = {29'h0, ck_view.split, r.chst[r.ch_sel]};
      default: mapped = 1'b0;
    endcase
    if (setup) begin
      n.pslverr = !mapped;
      n.prdata = pwrite ? 32'h0000_0000 : rd;
    end

    // register writes in the access cycle; clears before sets
    if (wr && mapped) begin
      case (paddr)
        INT_CLEAR_OFF: n.int_stat = r.int_stat & ~pwdata[IRQ_W-1:0];
        INT_ENABLE_OFF: n.int_en = pwdata[IRQ_W-1:0];
        FAULT_CLEAR_OFF: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (pwdata[i] && r.fsr[i]) begin
              n.fsr[i] = 1'b0;
              n.ftype[i] = 8'h00;
              n.chst[i] = CH_STOPPED;
            end
          end
        end
        MGR_FAULT_OFF: n.mgr_fault = r.mgr_fault & ~pwdata[0];
        INSN_OFF: n.insn = pwdata[INSN_W-1:0];
        EXEC_OFF: begin
          if (pwdata[0] && r.ex == EX_IDLE) begin
            n.ex = EX_RUN;
          end
        end
        CH_SEL_OFF: n.ch_sel = pwdata[CH_W-1:0];
        CH_SAR_OFF: n.sar[r.ch_sel] = pwdata;
        CH_DAR_OFF: n.dar[r.ch_sel] = pwdata;
        CH_CCR_OFF: n.ccr[r.ch_sel] = pwdata;
        default: n.ch_sel = r.ch_sel;
      endcase
    end

    // instruction step; faults execute as a no-op
    case (r.ex)
      EX_IDLE: n.ex = n.ex;
      EX_RUN: begin
        n.ex = EX_DONE;
        if (run_mgr) begin
          if (!dc.legal) begin
            n.mgr_fault = 1'b1;
            n.int_stat[IRQ_MGR_FAULT] = 1'b1;
          end else if (dc.is_go) begin
            if (r.chst[r.insn[8 +: CH_W]] == CH_STOPPED) begin
              n.chst[r.insn[8 +: CH_W]] = CH_EXEC;
            end
          end else if (dc.is_sev) begin
            n.int_stat[IRQ_EVENT] = 1'b1;
          end
        end else if (run_ch) begin
          if (!dc.legal) begin
            n.fsr[ich] = 1'b1;
            n.ftype[ich][FT_UNDEF] = 1'b1;
            n.chst[ich] = CH_FAULTC;
            n.int_stat[IRQ_CH_FAULT] = 1'b1;
          end else if ((dc.is_ld && ck_run.src_misaligned) ||
                       (dc.is_st && ck_run.dst_misaligned)) begin
            n.fsr[ich] = 1'b1;
            n.ftype[ich][FT_UNALIGNED] = 1'b1;
            n.chst[ich] = CH_FAULTC;
            n.int_stat[IRQ_CH_FAULT] = 1'b1;
          end else if (dc.is_adnh) begin
            if (dc.ra) begin
              n.dar[ich] = exp_addr;
            end else begin
              n.sar[ich] = exp_addr;
            end
          end else if (dc.is_sev) begin
            n.int_stat[IRQ_EVENT] = 1'b1;
          end else if (dc.is_end) begin
            n.chst[ich] = CH_STOPPED;
          end
        end
      end
      EX_DONE: n.ex = EX_IDLE;
      default: n.ex = EX_IDLE;
    endcase

    // shared merge buffer demand of all executing channels
    // 16 bits so eight channels of the largest bursts cannot wrap, and
    // the length is widened before the +1 so a length of 16 is kept
    for (int i = 0; i < NUM_CH; i++) begin
      if (r.chst[i] == CH_EXEC) begin
        demand = demand + ((16'h0001 << r.ccr[i][CCR_SRC_SIZE_LO +: 3]) *
                 ({12'h000, r.ccr[i][CCR_SRC_LEN_LO +: 4]} + 16'h0001));
      end
    end
    if (demand > {4'h0, MERGE_BYTES}) begin
      n.int_stat[IRQ_ABORT] = 1'b1;
    end
  end

  // state register; split beats are not stored anywhere, the split flag is only
  // computed from the sar, dar and ccr of the channel selected by ch_sel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_exec_write;
    wr && paddr == EXEC_OFF && pwdata[0] && r.ex == EX_IDLE;
  endsequence

  sequence s_step_done;
    r.ex == EX_RUN ##1 r.ex == EX_DONE ##1 r.ex == EX_IDLE;
  endsequence

  a_exec_launch: assert property (s_exec_write |=> s_step_done)
    else $error("instruction step did not run to completion");

  a_adnh_src_add: assert property (
    run_ch && dc.is_adnh && !dc.ra
    |=> r.sar[$past(ich)] == $past(exp_addr) &&
        $past(exp_addr) == $past(base) - {15'h0, $past(neg_mag)})
    else $error("adnh source result wrong");

  a_adnh_dst_sel: assert property (
    run_ch && dc.is_adnh && dc.ra
    |=> r.dar[$past(ich)] == $past(exp_addr) &&
        $stable(r.sar[$past(ich)]))
    else $error("adnh register select wrong");

  a_adnh_wraps: assert property (
    run_ch && dc.is_adnh && {15'h0, neg_mag} > base
    |=> (dc.ra ? r.dar[$past(ich)] : r.sar[$past(ich)]) > $past(base))
    else $error("adnh did not wrap");

  a_unaligned_read: assert property (
    run_ch && dc.legal && dc.is_ld && ck_run.src_misaligned
    |=> r.fsr[$past(ich)] && r.chst[$past(ich)] == CH_FAULTC &&
        r.ftype[$past(ich)][FT_UNALIGNED])
    else $error("unaligned fixed read not faulted");

  a_unaligned_write: assert property (
    run_ch && dc.legal && dc.is_st && ck_run.dst_misaligned
    |=> r.fsr[$past(ich)] && r.int_stat[IRQ_CH_FAULT])
    else $error("unaligned fixed write not faulted");

  a_mgr_adnh_undef: assert property (
    run_mgr && dc.is_adnh
    |=> r.mgr_fault && $stable(r.sar) && $stable(r.dar))
    else $error("manager adnh not faulted");

  a_go_chan_undef: assert property (
    run_ch && dc.is_go |=> r.fsr[$past(ich)] && r.ftype[$past(ich)][FT_UNDEF])
    else $error("go in channel thread not faulted");

  a_fault_nop_addr: assert property (
    run_ch && !dc.legal |=> $stable(r.sar) && $stable(r.dar) ##1
                            r.chst[$past(ich, 2)] == CH_FAULTC || wr)
    else $error("faulting instruction changed addresses");

  a_irq_level: assert property (
    (|(r.int_stat & r.int_en)) |=> irq)
    else $error("shared interrupt not raised");

  a_apb_answer: assert property (
    setup |=> pready ##1 !pready || setup)
    else $error("apb answer not one cycle");

  a_go_starts: assert property (
    run_mgr && dc.is_go && r.chst[r.insn[8 +: CH_W]] == CH_STOPPED
    |=> r.chst[r.insn[8 +: CH_W]] == CH_EXEC)
    else $error("manager go did not start the channel");

  a_chan_end_stop: assert property (
    run_ch && dc.is_end |=> r.chst[$past(ich)] == CH_STOPPED)
    else $error("channel end did not stop the channel");

  a_mgr_chan_kept: assert property (
    run_mgr && !wr |=> $stable(r.fsr) && $stable(r.sar))
    else $error("manager step touched channel state");

  a_split_byte: assert property (
    r.ccr[r.ch_sel][CCR_SRC_SIZE_LO +: 3] == 3'h0 |-> !ck_view.split)
    else $error("byte beats marked as split");

  a_split_same_lane: assert property (
    r.sar[r.ch_sel][3:0] == r.dar[r.ch_sel][3:0] |-> !ck_view.split)
    else $error("equal lane alignment marked as split");

  a_fault_status_irq: assert property (
    $rose(|r.fsr) |-> r.int_stat[IRQ_CH_FAULT])
    else $error("channel fault without fault status interrupt");

endmodule : chan_prog_check

/* File: rtl/instr_decode.sv */
// first-byte decoder with thread usage legality
// assumes op is the opcode byte and mgr marks the manager thread
`timescale 1ns/10ps
module instr_decode
  import chan_chk_pkg::*;
(
  // opcode in, classes out
  instr_dec_if.dec d
);
  logic both_ok;

  // opcode classes, the register select bit masked out for adnh
  assign d.is_adnh = (d.op & OP_RA_MASK) == OP_ADNH;
  assign d.ra = d.op[1];
  assign d.is_go = (d.op & OP_RA_MASK) == OP_GO;
  assign d.is_end = d.op == OP_END;
  assign d.is_sev = d.op == OP_SEV;
  assign d.is_ld = d.op == OP_LD;
  assign d.is_st = d.op == OP_ST;
  assign both_ok = d.is_end || d.op == OP_NOP || d.is_sev ||
                   d.op == OP_WFE;
  // go only in the manager; end, nop, sev, wfe in both; the rest only in channels
  assign d.legal = d.mgr ? (d.is_go || both_ok) : !d.is_go;
endmodule : instr_decode

/* File: tb/irq_sink.sv */
// level interrupt sink standing in for the host interrupt controller
// assumes irq is a registered level in the pclk domain
`timescale 1ns/10ps
module irq_sink (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // watched line and its count of assertions
  input wire logic irq,
  output int n_rise
);
  logic irq_r;

  // count each rising edge of the shared line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      n_rise <= 0;
    end else begin
      irq_r <= irq;
      if (irq && !irq_r) begin
        n_rise <= n_rise + 1;
      end
    end
  end
endmodule : irq_sink

/* File: tb/tb.sv */
// self-checking bench for the channel program checker
// assumes an apb slave that answers with pready and one 40 MHz clock
`timescale 1ns/10ps
module tb import chan_chk_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] q;
  logic err;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_rise;
  logic [7:0] mops [7] = '{OP_END, OP_NOP, OP_SEV, OP_WFE, OP_LD, OP_ST,
                           OP_ADNH};
  logic mbad [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [2:0] ssz [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h2};
  logic [3:0] ssar [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'he};
  logic [3:0] sdar [8] = '{4'h3, 4'h2, 4'h1, 4'h4, 4'h3, 4'h8, 4'h4, 4'h2};
  logic ssp [8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  // clock generation
  always #12.5 pclk = ~pclk;

  chan_prog_check dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq)
  );

  irq_sink sink_u (
    .pclk(pclk),
    .presetn(presetn),
    .irq(irq),
    .n_rise(n_rise)
  );

  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, read data and error are taken as sampled at one edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] exp,
                    input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(nm, q & m, exp);
  endtask : rd

  // instruction word: opcode, immediate low, high, channel, manager
  function automatic logic [31:0] mk(input logic m, input logic [2:0] c,
                                     input logic [7:0] op,
                                     input logic [15:0] im);
    return {4'h0, m, c, im, op};
  endfunction : mk

  // run one instruction step and wait until the step is over
  task automatic ex(input logic [31:0] insn);
    int n;
    wr(INSN_OFF, insn);
    wr(EXEC_OFF, 32'h1);
    n = 0;
    do begin
      apb(1'b0, EXEC_OFF, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (n == 20) num_errors++;
  endtask : ex

  task automatic go(input logic [2:0] c);
    ex(mk(1'b1, 3'h0, OP_GO, {13'h0, c}));
  endtask : go

  task automatic ctx(input logic [2:0] c, input logic [31:0] s,
                     input logic [31:0] d, input logic [31:0] cc);
    wr(CH_SEL_OFF, {29'h0, c});
    wr(CH_SAR_OFF, s);
    wr(CH_DAR_OFF, d);
    wr(CH_CCR_OFF, cc);
  endtask : ctx

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd("int_status", INT_STATUS_OFF, 32'h0);
    rd("ch_state", CH_STATE_OFF, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    // fixed unaligned source burst
    ctx(3'h1, 32'h1001, 32'h1000, 32'h4);
    go(3'h1);
    rd("ch1 exec", CH_STATE_OFF, 32'h1, 32'h3);
    ex(mk(1'b0, 3'h1, OP_LD, 16'h0));
    rd("fault status", FAULT_STATUS_OFF, 32'h2);
    rd("fault type", CH_FTYPE_OFF, 32'h2);
    rd("ch1 faulting", CH_STATE_OFF, 32'h3, 32'h3);
    rd("ch fault irq", INT_STATUS_OFF, 32'h2);
    wr(FAULT_CLEAR_OFF, 32'h2);
    wr(INT_CLEAR_OFF, 32'hf);
    rd("ch1 stopped", CH_STATE_OFF, 32'h0, 32'h3);
    // fixed unaligned destination burst
    ctx(3'h2, 32'h2000, 32'h2002, 32'h10000);
    go(3'h2);
    ex(mk(1'b0, 3'h2, OP_ST, 16'h0));
    rd("fault status", FAULT_STATUS_OFF, 32'h4);
    rd("fault type", CH_FTYPE_OFF, 32'h2);
    wr(FAULT_CLEAR_OFF, 32'h4);
    // add negative halfword on both address registers
    ctx(3'h3, 32'h00010005, 32'h20, 32'h4001);
    go(3'h3);
    ex(mk(1'b0, 3'h3, OP_ADNH, 16'h0000));
    rd("sar wrap", CH_SAR_OFF, 32'h5);
    ex(mk(1'b0, 3'h3, OP_ADNH | 8'h02, 16'hfff0));
    rd("dar sub", CH_DAR_OFF, 32'h10);
    rd("sar kept", CH_SAR_OFF, 32'h5);
    ex(mk(1'b0, 3'h3, OP_ADNH, 16'h1234));
    rd("sar ext", CH_SAR_OFF, 32'hffff1239);
    rd("no fault", FAULT_STATUS_OFF, 32'h0);
    // end inside a channel stops it; restart for the next test
    ex(mk(1'b0, 3'h3, OP_END, 16'h0));
    rd("ch3 ended", CH_STATE_OFF, 32'h0, 32'h3);
    go(3'h3);
    rd("ch3 restart", CH_STATE_OFF, 32'h1, 32'h3);
    // go is refused inside a channel thread
    ex(mk(1'b0, 3'h3, OP_GO, 16'h0));
    rd("go in chan", CH_FTYPE_OFF, 32'h1);
    wr(FAULT_CLEAR_OFF, 32'h8);
    // manager thread usage
    for (int i = 0; i < 7; i++) begin
      ex(mk(1'b1, 3'h0, mops[i], 16'h0));
      rd("mgr fault", MGR_FAULT_OFF, {31'h0, mbad[i]});
      wr(MGR_FAULT_OFF, 32'h1);
    end
    // shared interrupt: raise, mask, clear, re-enable
    wr(INT_CLEAR_OFF, 32'hf);
    wr(INT_ENABLE_OFF, 32'h1);
    ex(mk(1'b1, 3'h0, OP_SEV, 16'h0));
    chk("irq on", {31'h0, irq}, 32'h1);
    chk("irq edges", n_rise, 32'h1);
    wr(INT_ENABLE_OFF, 32'h0);
    rd("status kept", INT_STATUS_OFF, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(INT_CLEAR_OFF, 32'h1);
    wr(INT_ENABLE_OFF, 32'h1);
    rd("status clr", INT_STATUS_OFF, 32'h0);
    chk("irq idle", {31'h0, irq}, 32'h0);
    // split detection for source beat size codes 0 to 3
    for (int i = 0; i < 8; i++) begin
      ctx(3'h7, {28'h0, ssar[i]}, {28'h0, sdar[i]}, {28'h0, ssz[i], 1'b0});
      rd("split", CH_STATE_OFF, {29'h0, ssp[i], 2'b00}, 32'h4);
    end
    // merge buffer demand: 128 bytes per channel, third one overflows
    for (int c = 4; c < 7; c++) begin
      ctx(3'(c), 32'h0, 32'h0, 32'h40f7);
      go(3'(c));
      rd("abort", INT_STATUS_OFF, (c == 6) ? 32'h8 : 32'h0, 32'h8);
    end
    tally_and_finish();
  end
endmodule : tb
